// File: core/capsync_pkg.sv
// Purpose: shared constants and types for the capture sync/trigger selector
// Assumes: Avalon-MM slave with 32-bit data, byte addresses
// Notes: register offsets are byte addresses, one aligned word each
package capsync_pkg;

  // ************************************************************
  // bus and register map
  // ************************************************************
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFS_CTL2 = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_TIMER = 4'hc;

  // ************************************************************
  // capture_control_two field layout and reset
  // ************************************************************
  localparam int SEL_LSB = 0;
  localparam int SEL_W = 5;
  localparam int TRIG_STAT_BIT = 6;
  localparam int TRIG_MODE_BIT = 7;
  localparam int CASCADE_BIT = 8;
  localparam int PAIR_ACTIVE_BIT = 9;
  localparam logic [15:0] CTL2_RESET = 16'h0000;
  localparam logic [15:0] CTL2_WMASK = 16'h01df;

  // ************************************************************
  // interrupt status / mask layout
  // ************************************************************
  localparam int IRQ_W = 3;
  localparam int IRQ_SRC_EVT = 0;
  localparam int IRQ_ROLLOVER = 1;
  localparam int IRQ_TRIG_SET = 2;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

  // ************************************************************
  // timer
  // ************************************************************
  localparam int TMR_W = 16;
  localparam logic [TMR_W-1:0] TMR_RESET = 16'h0000;
  localparam logic [TMR_W-1:0] TMR_MAX = 16'hffff;

  // ************************************************************
  // source select codes
  // ************************************************************
  localparam logic [SEL_W-1:0] SEL_OCMP1 = 5'h01;
  localparam logic [SEL_W-1:0] SEL_CAPTMR1 = 5'h05;
  localparam logic [SEL_W-1:0] SEL_GPTMR1 = 5'h0b;
  localparam logic [SEL_W-1:0] SEL_CAPIRQ1 = 5'h10;
  localparam logic [SEL_W-1:0] SEL_CMP4 = 5'h16;
  localparam logic [SEL_W-1:0] SEL_CMP5 = 5'h17;
  localparam logic [SEL_W-1:0] SEL_CMP1 = 5'h18;
  localparam logic [SEL_W-1:0] SEL_CMP2 = 5'h19;
  localparam logic [SEL_W-1:0] SEL_CMP3 = 5'h1a;
  localparam logic [SEL_W-1:0] SEL_CONV = 5'h1b;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic [3:0] out_cmp;      // output compare 1..4
    logic [3:0] cap_roll;     // capture timer 1..4 rollover
    logic [4:0] gp_timer;     // general timer 1..5
    logic [3:0] cap_irq;      // capture interrupt 1..4
    logic [4:0] comparator;   // analog comparator 1..5
    logic conv_irq;           // converter interrupt
  } src_events_s;

  typedef enum logic [1:0] {
    TS_IDLE,
    TS_ARMED,
    TS_RUNNING
  } tmr_state_e;

endpackage

// File: core/capture_sync_trigger_select.sv
// Purpose: capture channel timer with selectable sync/trigger source
// Assumes: all event inputs synchronous to mclk, one-cycle pulses
// Notes: registers reached over Avalon-MM, one wait state per access
//
// Implementation choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/100ps

module capture_sync_trigger_select
  import capsync_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // event sources
  input wire src_events_s src_events,
  // partner channel of the cascade pair
  input wire logic partner_cascade_en,
  // channel outputs
  output logic [TMR_W-1:0] capture_timer,
  output logic timer_rollover,
  output logic sync_event,
  output logic cascade_active,
  output logic cascade_pair_enable,
  output logic irq
);

  // ************************************************************
  // state
  // ************************************************************
  logic [15:0] ctl2_ff;
  logic [IRQ_W-1:0] irq_status_ff;
  logic [IRQ_W-1:0] irq_mask_ff;
  logic [TMR_W-1:0] timer_ff;
  logic rollover_ff;
  logic src_evt_ff;
  logic waitreq_ff;
  logic [31:0] rdata_ff;
  logic irq_ff;
  logic pair_ff;
  tmr_state_e state_ff;
  tmr_state_e nxt_state;

  logic src_evt_raw;
  logic req;
  logic wr_take;
  logic rd_take;
  logic [15:0] wdata16;
  logic [15:0] lane_mask;
  logic trig_mode;
  logic trig_stat;
  logic [IRQ_W-1:0] irq_events;
  logic [31:0] nxt_rdata;
  logic [SEL_W-1:0] sel_code;
  logic sel_rsv;

  assign req = read | write;
  assign sel_code = ctl2_ff[SEL_LSB +: SEL_W];
  // reserved selects never fire, so they must not hold the timer either
  assign sel_rsv = (sel_code inside {5'h00, 5'h09, 5'h0a, 5'h14, 5'h15}) ||
                   (sel_code > SEL_CONV);
  assign trig_mode = ctl2_ff[TRIG_MODE_BIT] & ~sel_rsv;
  assign trig_stat = ctl2_ff[TRIG_STAT_BIT];
  assign wdata16 = writedata[15:0];
  assign lane_mask = {{8{byteenable[1]}}, {8{byteenable[0]}}};

  // ************************************************************
  // source selection
  // ************************************************************
  sync_source_mux u_mux (
    .sel(ctl2_ff[SEL_LSB +: SEL_W]),
    .src(src_events),
    .evt(src_evt_raw)
  );

  // one register stage: a selected source event in cycle n acts in cycle n+1
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      src_evt_ff <= 1'b0;
    end else begin
      src_evt_ff <= src_evt_raw;
    end
  end

  // ************************************************************
  // avalon-mm handshake
  // ************************************************************
  // waitrequest rests high; drops for one cycle once a request is seen
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      waitreq_ff <= 1'b1;
    end else begin
      waitreq_ff <= ~(req & waitreq_ff);
    end
  end

  assign wr_take = write & ~waitreq_ff;
  assign rd_take = read & waitreq_ff;

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    unique case (address)
      OFS_CTL2: nxt_rdata[15:0] = ctl2_ff;
      OFS_IRQ_STATUS: nxt_rdata[IRQ_W-1:0] = irq_status_ff;
      OFS_IRQ_MASK: nxt_rdata[IRQ_W-1:0] = irq_mask_ff;
      OFS_TIMER: nxt_rdata[TMR_W-1:0] = timer_ff;
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end

  // data loaded one edge early so it stands when waitrequest is low
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata_ff <= 32'h0000_0000;
    end else if (rd_take) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ************************************************************
  // capture_control_two
  // ************************************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctl2_ff <= CTL2_RESET;
    end else begin
      if (wr_take && address == OFS_CTL2) begin
        ctl2_ff <= (ctl2_ff & ~(CTL2_WMASK & lane_mask)) |
                   (wdata16 & CTL2_WMASK & lane_mask);
      end
      ctl2_ff[PAIR_ACTIVE_BIT] <= pair_ff;
      // event set wins over a software clear in the same cycle
      if (src_evt_ff && ctl2_ff[TRIG_MODE_BIT]) begin
        ctl2_ff[TRIG_STAT_BIT] <= 1'b1;
      end
    end
  end

  // ************************************************************
  // cascade pair
  // ************************************************************
  // only the odd and even enables together form the 32-bit pair
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pair_ff <= 1'b0;
    end else begin
      pair_ff <= ctl2_ff[CASCADE_BIT] & partner_cascade_en;
    end
  end

  // ************************************************************
  // timer control
  // ************************************************************
  // trigger mode holds the timer until the trigger status is set;
  // sync mode (and reserved selects) let it run free
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      TS_IDLE: nxt_state = trig_mode ? TS_ARMED : TS_RUNNING;
      TS_ARMED: begin
        if (!trig_mode) begin
          nxt_state = TS_RUNNING;
        end else if (trig_stat) begin
          nxt_state = TS_RUNNING;
        end
      end
      TS_RUNNING: begin
        if (trig_mode && !trig_stat) begin
          nxt_state = TS_ARMED;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_ff <= TS_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      timer_ff <= TMR_RESET;
    end else if (!trig_mode && src_evt_ff) begin
      timer_ff <= TMR_RESET; // sync restarts the count
    end else if (trig_mode && src_evt_ff && !trig_stat) begin
      timer_ff <= TMR_RESET; // trigger starts from zero
    end else if (state_ff == TS_RUNNING) begin
      timer_ff <= timer_ff + 16'h0001; // free run unless an event restarts the count
    end else if (state_ff == TS_ARMED) begin
      timer_ff <= TMR_RESET;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rollover_ff <= 1'b0;
    end else begin
      rollover_ff <= (state_ff == TS_RUNNING) && (timer_ff == TMR_MAX) &&
                     !src_evt_ff;
    end
  end

  // ************************************************************
  // interrupts
  // ************************************************************
  always_comb begin
    irq_events = '0;
    irq_events[IRQ_SRC_EVT] = src_evt_ff;
    irq_events[IRQ_ROLLOVER] = rollover_ff;
    irq_events[IRQ_TRIG_SET] = src_evt_ff & trig_mode & ~trig_stat;
  end

  // write one to clear; a same-cycle event keeps its bit
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_status_ff <= IRQ_RESET;
    end else if (wr_take && address == OFS_IRQ_STATUS && byteenable[0]) begin
      irq_status_ff <= (irq_status_ff & ~writedata[IRQ_W-1:0]) | irq_events;
    end else begin
      irq_status_ff <= irq_status_ff | irq_events;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_mask_ff <= IRQ_RESET;
    end else if (wr_take && address == OFS_IRQ_MASK && byteenable[0]) begin
      irq_mask_ff <= writedata[IRQ_W-1:0];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(irq_status_ff & irq_mask_ff);
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign readdata = rdata_ff;
  assign waitrequest = waitreq_ff;
  assign capture_timer = timer_ff;
  assign timer_rollover = rollover_ff;
  assign sync_event = src_evt_ff;
  assign cascade_active = pair_ff;
  assign cascade_pair_enable = ctl2_ff[CASCADE_BIT];
  assign irq = irq_ff;

endmodule

// File: core/sync_source_mux.sv
// Purpose: picks one event source by the 5-bit select code
// Assumes: every source is a one-cycle pulse on mclk
// Notes: purely combinational; the caller registers the result
`timescale 1ns/100ps
module sync_source_mux
  import capsync_pkg::*;
(
  // select and sources
  input wire logic [SEL_W-1:0] sel,
  input wire src_events_s src,
  // chosen event
  output logic evt
);

  logic [SEL_W-1:0] k;

  always_comb begin
    evt = 1'b0;
    k = 5'h00;
    // ascending groups: base code plus channel number; comparators and converter each by their own code
    if (sel >= SEL_OCMP1 && sel < SEL_CAPTMR1) begin
      k = sel - SEL_OCMP1;
      evt = src.out_cmp[k[1:0]];
    end else if (sel >= SEL_CAPTMR1 && sel <= 5'h08) begin
      k = sel - SEL_CAPTMR1;
      evt = src.cap_roll[k[1:0]];
    end else if (sel >= SEL_GPTMR1 && sel < SEL_CAPIRQ1) begin
      k = sel - SEL_GPTMR1;
      evt = src.gp_timer[k[2:0]];
    end else if (sel >= SEL_CAPIRQ1 && sel <= 5'h13) begin
      k = sel - SEL_CAPIRQ1;
      evt = src.cap_irq[k[1:0]];
    end else if (sel == SEL_CMP1) begin
      evt = src.comparator[0];
    end else if (sel == SEL_CMP2) begin
      evt = src.comparator[1];
    end else if (sel == SEL_CMP3) begin
      evt = src.comparator[2];
    end else if (sel == SEL_CMP4) begin
      evt = src.comparator[3];
    end else if (sel == SEL_CMP5) begin
      evt = src.comparator[4];
    end else if (sel == SEL_CONV) begin
      evt = src.conv_irq;
    end else begin
      evt = 1'b0; // reserved codes stay silent
    end
  end

endmodule

// File: dv/capture_sync_trigger_select_checker.sv
// Purpose: port-level checks of the sync/trigger selector
// Assumes: bound to the top module, one clock domain
// Notes: select and mode shadowed from bus writes
`timescale 1ns/100ps
module capture_sync_trigger_select_checker
  import capsync_pkg::*;
(
  // clock, reset and bus
  input wire logic mclk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic waitrequest,
  // events and channel outputs
  input wire src_events_s src_events,
  input wire logic partner_cascade_en,
  input wire logic [TMR_W-1:0] capture_timer,
  input wire logic timer_rollover,
  input wire logic sync_event,
  input wire logic cascade_active,
  input wire logic cascade_pair_enable
);
  // ************************************************************
  // shadow and properties
  // ************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic [8:0] ctl_ff;
  logic rsv;
  assign rsv = (ctl_ff[4:0] inside {5'h00, 5'h09, 5'h0a, 5'h14, 5'h15}) || ctl_ff[4:0] >= 5'h1c;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctl_ff <= '0;
    end else if (write && !waitrequest && address == OFS_CTL2) begin
      if (byteenable[0]) ctl_ff[7:0] <= writedata[7:0];
      if (byteenable[1]) ctl_ff[8] <= writedata[8];
    end
  end
  a_wait_one: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("access not answered in one cycle");
  a_wait_single: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low too long");
  a_sync_cause: assert property (sync_event |-> $past(|src_events))
    else $error("sync event without source pulse");
  a_reserved_quiet: assert property (sync_event |-> !$past(rsv))
    else $error("reserved code gave an event");
  a_sync_clears: assert property (sync_event && !ctl_ff[7] |=>
    capture_timer == TMR_RESET)
    else $error("sync did not clear timer");
  a_timer_step: assert property ($changed(capture_timer) |->
    capture_timer == TMR_RESET || capture_timer == 16'($past(capture_timer) + 16'h1))
    else $error("timer jumped");
  a_roll_cause: assert property (timer_rollover |->
    $past(capture_timer) == TMR_MAX || $past(capture_timer, 2) == TMR_MAX)
    else $error("rollover without full count");
  a_roll_pulse: assert property (timer_rollover |=> !timer_rollover)
    else $error("rollover longer than a cycle");
  a_cascade_both: assert property (cascade_active ==
    ($past(cascade_pair_enable) && $past(partner_cascade_en)))
    else $error("cascade active wrong");
  a_cascade_bit: assert property (cascade_pair_enable == ctl_ff[8])
    else $error("cascade enable not as written");
  c_sync: cover property (sync_event);
  c_roll: cover property (timer_rollover);
  c_cascade: cover property ($rose(cascade_active));
endmodule

// File: dv/event_source_model.sv
// Purpose: event sources on the far side of the selector
// Assumes: fire_idx picks one bit of the packed event vector
// Notes: every source is a one-cycle pulse, the rest stay low
`timescale 1ns/100ps
module event_source_model
  import capsync_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // command from the bench
  input wire logic fire,
  input wire logic [4:0] fire_idx,
  // events
  output src_events_s src
);
  // ************************************************************
  // pulse source
  // ************************************************************
  // never stretched: a held level would look like repeated events
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      src <= '0;
    end else begin
      src <= fire ? src_events_s'(23'h1 << fire_idx) : '0;
    end
  end
endmodule

// File: dv/test_capture_sync_trigger_select.sv
// Purpose: self-checking bench of the sync/trigger selector
// Assumes: one wait state per bus access
// Notes: scan uses trigger mode so comparator codes are legal
`timescale 1ns/100ps
module test_capture_sync_trigger_select
  import capsync_pkg::*;
;
  // ************************************************************
  // stimulus, tasks and scenarios
  // ************************************************************
  logic mclk = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0, fire = 1'b0, pce = 1'b0;
  logic [ADDR_W-1:0] address = '0;
  logic [31:0] writedata = '0;
  logic [3:0] byteenable = 4'hf;
  logic [4:0] fire_idx = '0;
  logic [31:0] readdata;
  logic [TMR_W-1:0] capture_timer;
  logic waitrequest, timer_rollover, sync_event, cascade_active, cascade_pair_enable, irq;
  src_events_s src_events;
  int num_errors = 0;
  int n_compared = 0;
  logic [15:0] q;
  always #20 mclk = ~mclk;
  event_source_model srcm (.mclk(mclk), .rst(rst), .fire(fire), .fire_idx(fire_idx),
    .src(src_events));
  capture_sync_trigger_select uut (.mclk(mclk), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .src_events(src_events), .partner_cascade_en(pce),
    .capture_timer(capture_timer), .timer_rollover(timer_rollover), .sync_event(sync_event),
    .cascade_active(cascade_active), .cascade_pair_enable(cascade_pair_enable), .irq(irq));
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // entered just after a rising edge, leaves one edge after release
  task automatic bus(input logic wr, input logic [3:0] a, input logic [15:0] d);
    int n;
    n = 0;
    address <= a;
    writedata <= {16'h0, d};
    write <= wr;
    read <= !wr;
    do begin
      @(posedge mclk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      num_errors++;
      report_and_stop();
    end
    q = readdata[15:0];
    write <= 1'b0;
    read <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic pulse(input int b);
    fire <= 1'b1;
    fire_idx <= 5'(b);
    @(posedge mclk);
    fire <= 1'b0;
    @(posedge mclk);
    @(negedge mclk);
  endtask
  function automatic int exp_bit(input int c);
    if (c >= 1 && c <= 4) return 18 + c;
    if (c >= 5 && c <= 8) return 10 + c;
    if (c >= 11 && c <= 15) return c - 1;
    if (c >= 16 && c <= 19) return c - 10;
    if (c == 22 || c == 23) return c - 18;
    if (c >= 24 && c <= 26) return c - 23;
    return (c == 27) ? 0 : -1;
  endfunction
  task automatic t_regs();
    bus(1'b0, OFS_CTL2, 16'h0);
    chk("ctl2 reset", CTL2_RESET, q);
    bus(1'b0, OFS_IRQ_MASK, 16'h0);
    chk("mask reset", 16'(IRQ_RESET), q);
    bus(1'b0, 4'h2, 16'h0);
    chk("unmapped", 16'h0, q);
    $display("t_regs done");
  endtask
  // this channel stands apart from the four routed ones
  // trigger mode kept so comparator and converter codes stay legal
  task automatic t_select();
    for (int c = 0; c < 32; c++) begin
      bus(1'b1, OFS_CTL2, 16'(c) | 16'h0080);
      for (int b = 0; b < 23; b++) begin
        pulse(b);
        chk("sync", 16'(exp_bit(c) == b), 16'(sync_event));
        @(posedge mclk);
      end
    end
    $display("t_select done");
  endtask
  task automatic t_trigger();
    bus(1'b1, OFS_IRQ_STATUS, 16'h0007);
    bus(1'b1, OFS_IRQ_MASK, 16'h0004);
    bus(1'b1, OFS_CTL2, 16'h008b);
    // arming lands one cycle after the write
    @(posedge mclk);
    bus(1'b0, OFS_TIMER, 16'h0);
    chk("held timer", 16'h0, q);
    pulse(10);
    @(posedge mclk);
    bus(1'b0, OFS_CTL2, 16'h0);
    chk("trig status", 16'h00cb, q);
    bus(1'b0, OFS_IRQ_STATUS, 16'h0);
    chk("irq status", 16'h0005, q);
    chk("irq", 16'h1, 16'(irq));
    bus(1'b1, OFS_IRQ_STATUS, 16'h0005);
    bus(1'b0, OFS_IRQ_STATUS, 16'h0);
    chk("irq cleared", 16'h1, 16'(irq === 1'b0 && q === 16'h0));
    bus(1'b1, OFS_CTL2, 16'h00cb);
    bus(1'b0, OFS_CTL2, 16'h0);
    chk("sw set", 16'h00cb, q);
    bus(1'b1, OFS_CTL2, 16'h008b);
    bus(1'b0, OFS_CTL2, 16'h0);
    chk("sw clear", 16'h008b, q);
    $display("t_trigger done");
  endtask
  task automatic t_sync();
    bus(1'b1, OFS_CTL2, 16'h000b);
    repeat (4) @(posedge mclk);
    pulse(10);
    chk("sync pulse", 16'h1, 16'(sync_event));
    chk("timer runs", 16'h1, 16'(capture_timer != TMR_RESET));
    @(negedge mclk);
    chk("sync clear", TMR_RESET, capture_timer);
    @(posedge mclk);
    $display("t_sync done");
  endtask
  task automatic t_cascade();
    bus(1'b1, OFS_CTL2, 16'h0300);
    bus(1'b0, OFS_CTL2, 16'h0);
    chk("one side only", 16'h0100, q);
    chk("pair off", 16'h0, 16'(cascade_active));
    chk("pair enable", 16'h1, 16'(cascade_pair_enable));
    pce <= 1'b1; // both channels set
    repeat (2) @(posedge mclk);
    bus(1'b0, OFS_CTL2, 16'h0);
    chk("cascade on", 16'h0300, q);
    chk("pair on", 16'h1, 16'(cascade_active));
    $display("t_cascade done");
  endtask
  task automatic t_roll();
    int n;
    n = 0;
    // trigger mode on a reserved code must still run free
    bus(1'b1, OFS_CTL2, 16'h0080);
    bus(1'b1, OFS_IRQ_MASK, 16'h0002);
    while (timer_rollover !== 1'b1 && n < 70000) begin
      @(posedge mclk);
      n++;
    end
    repeat (2) @(posedge mclk);
    chk("rollover irq", 16'h1, 16'(irq === 1'b1 && n < 70000));
    $display("t_roll done");
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    t_regs();
    t_select();
    t_trigger();
    t_sync();
    t_cascade();
    t_roll();
    report_and_stop();
  end
endmodule
bind capture_sync_trigger_select capture_sync_trigger_select_checker chk_i (.mclk(mclk),
  .rst(rst), .address(address), .read(read), .write(write), .writedata(writedata),
  .byteenable(byteenable), .waitrequest(waitrequest), .src_events(src_events),
  .partner_cascade_en(partner_cascade_en), .capture_timer(capture_timer),
  .timer_rollover(timer_rollover), .sync_event(sync_event), .cascade_active(cascade_active),
  .cascade_pair_enable(cascade_pair_enable));
